// >>> common/pcdi_regs.svh
// Register offsets, field positions and reset values of the port change detector
`ifndef PCDI_REGS_SVH
`define PCDI_REGS_SVH

// Per-port register block: port n starts at n * PCDI_PORT_STRIDE
`define PCDI_PORT_STRIDE 8'h08
`define PCDI_OFF_RISE 8'h00
`define PCDI_OFF_FALL 8'h01
`define PCDI_OFF_FLAG 8'h02
`define PCDI_OFF_PULLUP 8'h03
`define PCDI_OFF_PULLDOWN 8'h04

// Global registers
`define PCDI_ADDR_PAD_CONFIGURATION 8'h18
`define PCDI_ADDR_PORT_CHANGE_STATUS 8'h19
`define PCDI_ADDR_INTERRUPT_ENABLE 8'h1a

// Field positions
`define PCDI_BIT_CHANGE_DETECT_ENABLE 15
`define PCDI_BIT_PARALLEL_PORT_TTL 0
`define PCDI_BIT_GLOBAL_CHANGE_IE 3

// Reset values
`define PCDI_RESET_PAD_CONFIGURATION 16'h0000
`define PCDI_RESET_PORT_REG 16'h0000

`endif

// >>> common/pcdi_pkg.sv
// Types shared by the port change detector
package pcdi_pkg;

    localparam int PCDI_PORTS = 3;

    // Whole state of the detector, registered in one process
    typedef struct packed {
        logic [2:0][15:0] rise_edge_enable;
        logic [2:0][15:0] fall_edge_enable;
        logic [2:0][15:0] pin_change_flag;
        logic [2:0][15:0] weak_pullup_enable;
        logic [2:0][15:0] weak_pulldown_enable;
        logic [2:0][15:0] last_level;
        logic [2:0] port_change_summary;
        logic change_detect_enable;
        logic parallel_port_input_type;
        logic global_change_ie;
        logic change_interrupt;
        logic [15:0] read_data;
    } pcdi_state_t;

endpackage : pcdi_pkg

// >>> core/pcdi_core.sv
// Change-of-state detector with sticky pin flags for three 16-bit ports
//
// How it works
// RULE_01: Detect enabled pin changes and raise an interrupt request to the processor.
// RULE_02: Rising-edge enable set: each low-to-high transition records a change event.
// RULE_03: Falling-edge enable set: each high-to-low transition records a change event.
// RULE_04: Both enables set: either edge counts, so one pulse gives two events.
// RULE_05: Detection needs global enable, pad change-detect enable, and interrupt flag clear.
// RULE_06: A change event sets that pin's bit in the port's flag register.
// RULE_07: Pin flags stay set until software writes zero; writing one keeps them.
// RULE_08: Port summary bit sets whenever any pin flag of that port is set.
// RULE_09: Port summary bit clears by itself once all sixteen pin flags clear.
// RULE_10: An edge arriving during a clearing write still leaves its flag set.
// RULE_11: Software clears flags by XOR with all ones, then AND back.
// RULE_12: Software should touch flag registers only in the handler or interrupts off.
// RULE_13: Every pin has individually enabled weak pull-up and weak pull-down controls.
// RULE_14: Software keeps pulls disabled on pins configured as digital outputs.
// RULE_15: Pad configuration bit 15 enables change detection; read/write, resets to 0.
// RULE_16: Pad configuration bit 0 selects TTL (1) or Schmitt (0); resets 0.
// RULE_17: Pad configuration bits 14 down to 1 always read as zero.
// RULE_18: Status register holds read-only summaries at bits 0..2; others read zero.
// RULE_19: Software waits one instruction cycle between port write and port read.
// RULE_20: Interrupt request stands while any summary bit is set and detection enabled.
// RULE_21: Each pin is compared with its previously captured level to find edges.
`timescale 1ns/10ps
`include "pcdi_regs.svh"

module pcdi_core
    import pcdi_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [47:0] pin_level_in,
    input wire logic interrupt_status_flag_in,
    output logic change_interrupt_out,
    output logic [47:0] weak_pullup_out,
    output logic [47:0] weak_pulldown_out,
    output logic parallel_port_input_type_out
);

    pcdi_state_t st;
    pcdi_state_t next_st;

    // Detection gate shared by all ports
    logic detect_gate;
    // Event vectors, kept visible for the checks below
    logic [2:0][15:0] rise_event;
    logic [2:0][15:0] fall_event;
    logic [2:0][15:0] pin_now;
    logic [2:0] flag_wr;

    assign pin_now = pin_level_in;

    // Flags only get set while the whole enable chain is open; writes clear them regardless
    assign detect_gate = st.global_change_ie && st.change_detect_enable
        && !interrupt_status_flag_in; // RULE_05

    // Next-state logic: register writes, edge detection, summaries, request
    always_comb
    begin
        logic [7:0] base;
        logic any_summary;
        next_st = st;
        base = 8'h00;
        any_summary = 1'b0;
        rise_event = '0;
        fall_event = '0;
        flag_wr = '0;
        for (int p = 0; p < PCDI_PORTS; p++)
        begin
            base = 8'(p) * `PCDI_PORT_STRIDE;
            // Edges come from the level captured last cycle, not from a sampled strobe
            rise_event[p] = pin_now[p] & ~st.last_level[p]
                & st.rise_edge_enable[p] & {16{detect_gate}}; // RULE_02 RULE_21
            fall_event[p] = ~pin_now[p] & st.last_level[p]
                & st.fall_edge_enable[p] & {16{detect_gate}}; // RULE_03 RULE_21
            // Last level always tracks the pin so enabling never fakes an edge
            next_st.last_level[p] = pin_now[p]; // RULE_21
            if (reg_write_in && reg_addr_in == base + `PCDI_OFF_RISE)
            begin
                next_st.rise_edge_enable[p] = reg_wdata_in;
            end
            if (reg_write_in && reg_addr_in == base + `PCDI_OFF_FALL)
            begin
                next_st.fall_edge_enable[p] = reg_wdata_in;
            end
            if (reg_write_in && reg_addr_in == base + `PCDI_OFF_PULLUP)
            begin
                next_st.weak_pullup_enable[p] = reg_wdata_in; // RULE_13
            end
            if (reg_write_in && reg_addr_in == base + `PCDI_OFF_PULLDOWN)
            begin
                next_st.weak_pulldown_enable[p] = reg_wdata_in; // RULE_13
            end
            flag_wr[p] = reg_write_in && reg_addr_in == base + `PCDI_OFF_FLAG;
            // Writing zero clears, writing one keeps; a new edge beats the clear
            if (flag_wr[p])
            begin
                next_st.pin_change_flag[p] = st.pin_change_flag[p] & reg_wdata_in; // RULE_07
            end
            next_st.pin_change_flag[p] = next_st.pin_change_flag[p]
                | rise_event[p] | fall_event[p]; // RULE_06 RULE_04 RULE_10
            // Summary follows the flags, set and cleared by hardware only
            next_st.port_change_summary[p] = |next_st.pin_change_flag[p]; // RULE_08 RULE_09
            any_summary = any_summary | next_st.port_change_summary[p];
        end

        // Global registers
        if (reg_write_in && reg_addr_in == `PCDI_ADDR_PAD_CONFIGURATION)
        begin
            next_st.change_detect_enable =
                reg_wdata_in[`PCDI_BIT_CHANGE_DETECT_ENABLE]; // RULE_15
            next_st.parallel_port_input_type =
                reg_wdata_in[`PCDI_BIT_PARALLEL_PORT_TTL]; // RULE_16
        end
        if (reg_write_in && reg_addr_in == `PCDI_ADDR_INTERRUPT_ENABLE)
        begin
            next_st.global_change_ie = reg_wdata_in[`PCDI_BIT_GLOBAL_CHANGE_IE];
        end

        // Request uses the freshly computed enables so it drops with them
        next_st.change_interrupt = any_summary && next_st.change_detect_enable
            && next_st.global_change_ie; // RULE_20 RULE_01

        // Read data stands only in the cycle after the read strobe
        next_st.read_data = 16'h0000;
        if (reg_read_in)
        begin
            for (int p = 0; p < PCDI_PORTS; p++)
            begin
                base = 8'(p) * `PCDI_PORT_STRIDE;
                if (reg_addr_in == base + `PCDI_OFF_RISE)
                begin
                    next_st.read_data = st.rise_edge_enable[p];
                end
                if (reg_addr_in == base + `PCDI_OFF_FALL)
                begin
                    next_st.read_data = st.fall_edge_enable[p];
                end
                if (reg_addr_in == base + `PCDI_OFF_FLAG)
                begin
                    next_st.read_data = st.pin_change_flag[p];
                end
                if (reg_addr_in == base + `PCDI_OFF_PULLUP)
                begin
                    next_st.read_data = st.weak_pullup_enable[p];
                end
                if (reg_addr_in == base + `PCDI_OFF_PULLDOWN)
                begin
                    next_st.read_data = st.weak_pulldown_enable[p];
                end
            end
            case (reg_addr_in)
                `PCDI_ADDR_PAD_CONFIGURATION:
                begin
                    // Middle bits are unimplemented and stay zero
                    next_st.read_data[`PCDI_BIT_CHANGE_DETECT_ENABLE] =
                        st.change_detect_enable; // RULE_17
                    next_st.read_data[`PCDI_BIT_PARALLEL_PORT_TTL] =
                        st.parallel_port_input_type;
                end
                `PCDI_ADDR_PORT_CHANGE_STATUS:
                begin
                    next_st.read_data[2:0] = st.port_change_summary; // RULE_18
                end
                `PCDI_ADDR_INTERRUPT_ENABLE:
                begin
                    next_st.read_data[`PCDI_BIT_GLOBAL_CHANGE_IE] = st.global_change_ie;
                end
                default:
                begin
                    // Unmapped and per-port addresses keep what the loop chose
                end
            endcase
        end
    end

    // State register; synchronous reset loads the documented zeros
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata_out = st.read_data;
    assign change_interrupt_out = st.change_interrupt;
    assign weak_pullup_out = st.weak_pullup_enable;
    assign weak_pulldown_out = st.weak_pulldown_enable;
    assign parallel_port_input_type_out = st.parallel_port_input_type;

    // Checks on the detector's own behaviour
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    sequence s_rise_seen;
        detect_gate && (rise_event[0] != 16'h0000);
    endsequence

    sequence s_fall_seen;
        detect_gate && (fall_event[0] != 16'h0000);
    endsequence

    property p_rise_sets_flag;
        s_rise_seen |=> ((st.pin_change_flag[0] & $past(rise_event[0])) == $past(rise_event[0]));
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag) // RULE_02
        else $error("Rising edge did not set its pin flag");

    property p_fall_sets_flag;
        s_fall_seen |=> ((st.pin_change_flag[0] & $past(fall_event[0])) == $past(fall_event[0]));
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag) // RULE_03
        else $error("Falling edge did not set its pin flag");

    property p_both_edges;
        (detect_gate && st.rise_edge_enable[1][0] && st.fall_edge_enable[1][0]
            && (pin_now[1][0] != st.last_level[1][0])) |=> st.pin_change_flag[1][0];
    endproperty
    a_both_edges: assert property (p_both_edges) // RULE_04
        else $error("Either edge with both enables failed to set flag");

    property p_gate_holds_flags;
        (!detect_gate && !flag_wr[2]) |=> $stable(st.pin_change_flag[2]);
    endproperty
    a_gate_holds_flags: assert property (p_gate_holds_flags) // RULE_05
        else $error("Flag changed while detection was gated off");

    property p_write_one_keeps;
        (flag_wr[0] && reg_wdata_in == 16'hffff)
            |=> (($past(st.pin_change_flag[0]) & ~st.pin_change_flag[0]) == 16'h0000);
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) // RULE_07
        else $error("Writing one cleared a pin flag");

    property p_set_wins;
        (flag_wr[1] && reg_wdata_in == 16'h0000 && detect_gate
            && ((rise_event[1] | fall_event[1]) != 16'h0000))
            |=> (st.pin_change_flag[1] != 16'h0000);
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE_10
        else $error("Edge lost during a clearing write");

    property p_summary_tracks;
        st.port_change_summary == {|st.pin_change_flag[2], |st.pin_change_flag[1],
            |st.pin_change_flag[0]};
    endproperty
    a_summary_tracks: assert property (p_summary_tracks) // RULE_08 RULE_09
        else $error("Summary bits disagree with pin flags");

    property p_status_read;
        (reg_read_in && reg_addr_in == `PCDI_ADDR_PORT_CHANGE_STATUS)
            |=> (reg_rdata_out == {13'h0000, $past(st.port_change_summary)});
    endproperty
    a_status_read: assert property (p_status_read) // RULE_18
        else $error("Status read returned wrong value");

    property p_pad_reserved;
        (reg_read_in && reg_addr_in == `PCDI_ADDR_PAD_CONFIGURATION)
            |=> (reg_rdata_out[14:1] == 14'h0000);
    endproperty
    a_pad_reserved: assert property (p_pad_reserved) // RULE_17
        else $error("Reserved pad configuration bits read nonzero");

    property p_request;
        ##1 (change_interrupt_out == ((|st.port_change_summary)
            && st.change_detect_enable && st.global_change_ie));
    endproperty
    a_request: assert property (p_request) // RULE_20
        else $error("Interrupt request disagrees with summary and enables");

    property p_pullup_write;
        (reg_write_in && reg_addr_in == `PCDI_OFF_PULLUP)
            |=> (weak_pullup_out[15:0] == $past(reg_wdata_in));
    endproperty
    a_pullup_write: assert property (p_pullup_write) // RULE_13
        else $error("Port A pull-up enables did not take the written value");

    property p_pulldown_write;
        (reg_write_in && reg_addr_in == `PCDI_PORT_STRIDE * 8'h02 + `PCDI_OFF_PULLDOWN)
            |=> (weak_pulldown_out[47:32] == $past(reg_wdata_in));
    endproperty
    a_pulldown_write: assert property (p_pulldown_write) // RULE_13
        else $error("Port C pull-down enables did not take the written value");

    property p_detect_enable_write;
        (reg_write_in && reg_addr_in == `PCDI_ADDR_PAD_CONFIGURATION)
            |=> (st.change_detect_enable == $past(reg_wdata_in[`PCDI_BIT_CHANGE_DETECT_ENABLE]));
    endproperty
    a_detect_enable_write: assert property (p_detect_enable_write) // RULE_15
        else $error("Change-detect enable did not follow its pad configuration bit");

    property p_input_type_write;
        (reg_write_in && reg_addr_in == `PCDI_ADDR_PAD_CONFIGURATION)
            |=> (parallel_port_input_type_out == $past(reg_wdata_in[`PCDI_BIT_PARALLEL_PORT_TTL]));
    endproperty
    a_input_type_write: assert property (p_input_type_write) // RULE_16
        else $error("Input type select did not follow its pad configuration bit");

    property p_flag_clear;
        (flag_wr[2] && ((rise_event[2] | fall_event[2]) == 16'h0000))
            |=> (st.pin_change_flag[2] == ($past(st.pin_change_flag[2]) & $past(reg_wdata_in)));
    endproperty
    a_flag_clear: assert property (p_flag_clear) // RULE_07
        else $error("Flag write did not clear exactly the zero bits");

    property p_flag_sticky;
        !flag_wr[0]
            |=> (($past(st.pin_change_flag[0]) & ~st.pin_change_flag[0]) == 16'h0000);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RULE_07
        else $error("Pin flag dropped without a software write");

    property p_status_flag_blocks;
        (interrupt_status_flag_in && !flag_wr[0])
            |=> ((st.pin_change_flag[0] & ~$past(st.pin_change_flag[0])) == 16'h0000);
    endproperty
    a_status_flag_blocks: assert property (p_status_flag_blocks) // RULE_05
        else $error("Pin flag set while the interrupt status flag was high");

    property p_level_tracks;
        1'b1
            |=> (st.last_level == $past(pin_now));
    endproperty
    a_level_tracks: assert property (p_level_tracks) // RULE_21
        else $error("Captured pin level does not follow the pins");

    property p_request_needs_enable;
        (!st.change_detect_enable || !st.global_change_ie)
            |-> !change_interrupt_out;
    endproperty
    a_request_needs_enable: assert property (p_request_needs_enable) // RULE_20
        else $error("Interrupt request raised with detection disabled");

endmodule : pcdi_core

// >>> dv/tb_top.sv
// Self-checking bench for the port change detector, compared against a reference model
`timescale 1ns/10ps
`include "pcdi_regs.svh"

module tb_top;
    import pcdi_pkg::*;

    logic clock_in, reset_in, reg_write_in, reg_read_in, interrupt_status_flag_in;
    logic [7:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [47:0] pin_level_in, weak_pullup_out, weak_pulldown_out, nx_p;
    logic change_interrupt_out, parallel_port_input_type_out, nx_i;
    int m_rise[3], m_fall[3], m_flag[3], m_pu[3], m_pd[3], m_last[3];
    int m_cde, m_ttl, m_gie, exp_rd, started, n_errors, checks, seed, i;
    logic [31:0] v, rv;
    logic [63:0] t;
    logic [7:0] a;

    pcdi_core DUT (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .pin_level_in(pin_level_in),
        .interrupt_status_flag_in(interrupt_status_flag_in),
        .change_interrupt_out(change_interrupt_out), .weak_pullup_out(weak_pullup_out),
        .weak_pulldown_out(weak_pulldown_out),
        .parallel_port_input_type_out(parallel_port_input_type_out));

    // 20 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic int summary();
        return int'(m_flag[0] != 0) | (int'(m_flag[1] != 0) << 1) | (int'(m_flag[2] != 0) << 2);
    endfunction : summary

    // Model read value, taken from the state before the read edge
    function automatic int rd_model(input int ad);
        if (ad == 8'h18) return (m_cde << 15) | m_ttl;
        if (ad == 8'h19) return summary();
        if (ad == 8'h1a) return m_gie << 3;
        if (ad >= 8'h18 || ad % 8 > 4) return 0;
        case (ad % 8)
            0: return m_rise[ad / 8];
            1: return m_fall[ad / 8];
            2: return m_flag[ad / 8];
            3: return m_pu[ad / 8];
            default: return m_pd[ad / 8];
        endcase
    endfunction : rd_model

    // One clock edge of the model, using the inputs the design samples at the same edge
    task automatic model_step;
        int k, cur, ev, gate, ad, d;
        ad = reg_addr_in;
        d = reg_wdata_in;
        exp_rd = reg_read_in ? rd_model(ad) : 0;
        gate = m_gie & m_cde & int'(!interrupt_status_flag_in);
        for (k = 0; k < 3; k++)
        begin
            cur = pin_level_in[16 * k +: 16];
            ev = (cur & ~m_last[k] & m_rise[k]) | (~cur & m_last[k] & m_fall[k]);
            m_last[k] = cur;
            if (reg_write_in)
            begin
                case (ad - 8 * k)
                    0: m_rise[k] = d;
                    1: m_fall[k] = d;
                    2: m_flag[k] = m_flag[k] & d;
                    3: m_pu[k] = d;
                    4: m_pd[k] = d;
                    default: ;
                endcase
            end
            // Set beats a simultaneous clear, so no event is lost
            m_flag[k] = m_flag[k] | (gate ? ev & 16'hffff : 0);
        end
        if (reg_write_in && ad == 8'h18)
        begin
            m_cde = (d >> 15) & 1;
            m_ttl = d & 1;
        end
        if (reg_write_in && ad == 8'h1a) m_gie = (d >> 3) & 1;
    endtask : model_step

    // One bus cycle: model the edge, then launch the next inputs
    task automatic op(input logic w, input logic r, input logic [7:0] ad, input logic [15:0] d);
        @(posedge clock_in);
        model_step();
        reg_write_in <= w;
        reg_read_in <= r;
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        pin_level_in <= nx_p;
        interrupt_status_flag_in <= nx_i;
    endtask : op

    // Software's clear: read the flags, invert what was seen, AND it back
    task automatic clear_flags(input logic [7:0] ad);
        logic [15:0] seen;
        op(0, 1, ad, 16'h0000);
        op(0, 0, 8'h00, 16'h0000);
        @(negedge clock_in);
        seen = reg_rdata_out;
        op(1, 0, ad, 16'hffff ^ seen);
    endtask : clear_flags

    // Outputs are compared mid-cycle, well clear of the launching edge
    always @(negedge clock_in)
    begin
        if (started != 0)
        begin
            check("read_data", reg_rdata_out, 48'(exp_rd));
            check("pullup", weak_pullup_out, {m_pu[2][15:0], m_pu[1][15:0], m_pu[0][15:0]});
            check("pulldown", weak_pulldown_out, {m_pd[2][15:0], m_pd[1][15:0], m_pd[0][15:0]});
            check("input_type", parallel_port_input_type_out, 48'(m_ttl));
            check("irq", change_interrupt_out, 48'(summary() != 0 && m_cde && m_gie));
        end
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Run is about 3030 cycles; the limit leaves ample margin
    initial
    begin
        #1000000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        seed = 32'h8c1d;
        {reg_write_in, reg_read_in, interrupt_status_flag_in, nx_i} = 4'h0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 16'h0000;
        pin_level_in = 48'h0;
        nx_p = 48'h0;
        reset_in = 1'b1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        started = 1;
        // Reset values, read-only status, unmapped place, unimplemented bits
        op(0, 1, `PCDI_ADDR_PAD_CONFIGURATION, 16'h0000);
        op(0, 1, `PCDI_ADDR_PORT_CHANGE_STATUS, 16'h0000);
        op(0, 1, 8'h1f, 16'h0000);
        op(1, 0, `PCDI_ADDR_PAD_CONFIGURATION, 16'hffff);
        op(0, 1, `PCDI_ADDR_PAD_CONFIGURATION, 16'h0000);
        op(1, 0, `PCDI_ADDR_PORT_CHANGE_STATUS, 16'hffff);
        op(0, 1, `PCDI_ADDR_PORT_CHANGE_STATUS, 16'h0000);
        // Enable detection: rising on port A, both edges on port B
        op(1, 0, `PCDI_ADDR_INTERRUPT_ENABLE, 16'h0008);
        op(1, 0, `PCDI_ADDR_PAD_CONFIGURATION, 16'h8000);
        op(1, 0, 8'h00, 16'hffff);
        op(1, 0, 8'h08, 16'hffff);
        op(1, 0, 8'h09, 16'hffff);
        nx_p = 48'h0000_0001_0001;
        op(0, 0, 8'h00, 16'h0000);
        nx_p = 48'h0;
        op(0, 1, 8'h02, 16'h0000);
        op(1, 0, 8'h02, 16'hfffe);
        // Edge arriving in the same cycle as the clearing write
        nx_p = 48'h1;
        op(1, 0, 8'h02, 16'h0000);
        op(0, 1, 8'h02, 16'h0000);
        op(0, 1, 8'h0a, 16'h0000);
        op(0, 1, `PCDI_ADDR_PORT_CHANGE_STATUS, 16'h0000);
        // Writing ones keeps a set flag
        op(1, 0, 8'h02, 16'hffff);
        // Edge on port B in the same cycle as zeroing its flags
        nx_p = 48'h0000_0001_0001;
        op(1, 0, 8'h0a, 16'h0000);
        op(0, 1, 8'h0a, 16'h0000);
        // Cleared only while the request stands, as a handler would
        clear_flags(8'h0a);
        op(0, 1, 8'h0a, 16'h0000);
        op(0, 1, `PCDI_ADDR_PORT_CHANGE_STATUS, 16'h0000);
        // Random traffic: pin toggles, gating flag, writes and reads at addresses 0x00 to 0x1b
        // Every pin stays an input here, so any pull setting is legal
        for (i = 0; i < 3000; i++)
        begin
            v = $random(seed);
            rv = $random(seed);
            t = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
            t = t & {$random(seed), $random(seed)};
            nx_p = nx_p ^ t[47:0];
            nx_i = (v[6:4] == 3'h0);
            a = (v[9:8] == 2'h3) ? {6'h06, v[11:10]} : {3'h0, v[9:8], v[12:10]};
            if (v[1:0] == 2'h0)
                op(1, 0, a, rv[15:0]);
            else if (v[1:0] == 2'h1)
                op(0, 1, a, 16'h0000);
            else
                op(0, 0, 8'h00, 16'h0000);
        end
        op(0, 0, 8'h00, 16'h0000);
        @(negedge clock_in);
        wrap_up();
    end
endmodule : tb_top
